//--- rtl/hsp_consts.svh
// Offsets, field positions and fixed values of the structural parameters register
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

`define HSP_SP_OFFSET 8'h04
`define HSP_ROUTE_OFFSET 8'h0c
`define HSP_CC_MSB 15
`define HSP_CC_LSB 12
`define HSP_PCC_MSB 11
`define HSP_PCC_LSB 8
`define HSP_PRR_BIT 7
`define HSP_PPC_BIT 4
`define HSP_NP_MSB 3
`define HSP_NP_LSB 0
`define HSP_CC_VALUE 4'h1
`define HSP_PCC_VALUE 4'h2
`define HSP_PRR_VALUE 1'h1
`define HSP_PPC_VALUE 1'h1
`define HSP_NP_VALUE 4'h2
`define HSP_SP_VALUE 32'h0000_1292
`define HSP_MAX_PORTS 15

`endif

//--- rtl/hsp_pkg.sv
// Types and shared helper for the structural parameters block
package hsp_pkg;

    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hsp_req_type;

    typedef struct packed {
        logic ack;
        logic hit;
        logic [31:0] rdata;
    } hsp_resp_type;

    typedef struct packed {
        logic companion_present;
        logic handoff_supported;
        logic route_array_valid;
        logic port_power_switch_present;
        logic [3:0] port_count;
    } hsp_caps_type;

    // Companion index of a port under consecutive-group routing
    function automatic logic [3:0] hsp_group_of(input logic [3:0] port, input logic [3:0] per_cc);
        logic [3:0] res;
        res = 4'h0;
        if (per_cc != 4'h0) begin
            res = port / per_cc;
        end
        return res;
    endfunction

endpackage

//--- rtl/hsp_route_calc.sv
// Companion assignment of each root port, from the routing rule
`timescale 1ns/1ps
module hsp_route_calc
    import hsp_pkg::*;
#(
    parameter int NUM_PORTS = 2
) (
    input wire logic routing_rule,
    input wire logic [3:0] per_cc,
    input wire logic [NUM_PORTS*4-1:0] route_array,
    output logic [NUM_PORTS*4-1:0] companion_of
);

    always_comb begin
        companion_of = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (routing_rule) begin
                companion_of[p*4 +: 4] = route_array[p*4 +: 4];
            end else begin
                companion_of[p*4 +: 4] = hsp_group_of(4'(p), per_cc);
            end
        end
    end

endmodule

//--- rtl/hsp_struct_params.sv
// Structural parameters capability register with its access port and derived capability flags
`timescale 1ns/1ps
`include "hsp_consts.svh"

module hsp_struct_params
    import hsp_pkg::*;
#(
    parameter logic [3:0] NUM_CC = `HSP_CC_VALUE,
    parameter logic [3:0] PORTS_PER_CC = `HSP_PCC_VALUE,
    parameter logic ROUTE_RULE = `HSP_PRR_VALUE,
    parameter logic POWER_SWITCH = `HSP_PPC_VALUE,
    parameter logic [3:0] NUM_PORTS = `HSP_NP_VALUE,
    parameter int ROUTE_PORTS = 2,
    parameter logic [ROUTE_PORTS*4-1:0] ROUTE_ARRAY = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire hsp_req_type acc,
    output hsp_resp_type resp,
    output hsp_caps_type caps,
    output logic [ROUTE_PORTS*4-1:0] port_companion
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire logic rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register image

    logic [31:0] sp_value;

    always_comb begin
        sp_value = '0;
        sp_value[`HSP_CC_MSB:`HSP_CC_LSB] = NUM_CC;
        sp_value[`HSP_PCC_MSB:`HSP_PCC_LSB] = PORTS_PER_CC;
        sp_value[`HSP_PRR_BIT] = ROUTE_RULE;
        sp_value[`HSP_PPC_BIT] = POWER_SWITCH;
        sp_value[`HSP_NP_MSB:`HSP_NP_LSB] = NUM_PORTS;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access port: one-cycle answer, writes dropped

    hsp_resp_type resp_r;
    hsp_resp_type resp_nxt;

    always_comb begin
        resp_nxt = '0;
        if (acc.req) begin
            resp_nxt.ack = 1'b1;
            resp_nxt.hit = (acc.addr == `HSP_SP_OFFSET);
            // Write data never reaches any storage
            if (!acc.we && resp_nxt.hit) begin
                resp_nxt.rdata = sp_value;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_r <= '0;
        end else if (clk_en) begin
            resp_r <= resp_nxt;
        end
    end

    assign resp = resp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Capability flags for the rest of the controller

    hsp_caps_type caps_r;
    hsp_caps_type caps_nxt;

    always_comb begin
        caps_nxt.companion_present = (NUM_CC != 4'h0);
        caps_nxt.handoff_supported = (NUM_CC != 4'h0);
        caps_nxt.route_array_valid = ROUTE_RULE;
        caps_nxt.port_power_switch_present = POWER_SWITCH;
        caps_nxt.port_count = NUM_PORTS;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            caps_r <= '0;
        end else if (clk_en) begin
            caps_r <= caps_nxt;
        end
    end

    assign caps = caps_r;

    ////////////////////////////////////////////////////////////////////////////
    // Port to companion routing

    logic [ROUTE_PORTS*4-1:0] comp_calc;
    logic [ROUTE_PORTS*4-1:0] comp_r;
    logic [ROUTE_PORTS*4-1:0] comp_nxt;

    hsp_route_calc #(
        .NUM_PORTS(ROUTE_PORTS)
    ) u_route (
        .routing_rule(ROUTE_RULE),
        .per_cc(PORTS_PER_CC),
        .route_array(ROUTE_ARRAY),
        .companion_of(comp_calc)
    );

    always_comb begin
        comp_nxt = comp_calc;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_r <= '0;
        end else if (clk_en) begin
            comp_r <= comp_nxt;
        end
    end

    assign port_companion = comp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic run_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_r <= 1'b0;
        end else if (clk_en) begin
            run_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence read_sp_s;
        clk_en && acc.req && !acc.we && acc.addr == `HSP_SP_OFFSET;
    endsequence

    sequence write_any_s;
        clk_en && acc.req && acc.we;
    endsequence

    read_value_a: assert property (read_sp_s |=> resp.ack && resp.hit && resp.rdata == `HSP_SP_VALUE)
        else $error("structural parameters read returned wrong value");

    offset_decode_a: assert property (clk_en && acc.req && acc.addr != `HSP_SP_OFFSET |=> !resp.hit && resp.rdata == 32'h0)
        else $error("unmapped offset answered as hit");

    write_ignored_a: assert property (write_any_s ##1 read_sp_s |=> resp.rdata == `HSP_SP_VALUE)
        else $error("write changed the register image");

    write_no_data_a: assert property (write_any_s |=> resp.ack && resp.rdata == 32'h0)
        else $error("write returned read data");

    idle_quiet_a: assert property (clk_en && !acc.req |=> !resp.ack && !resp.hit)
        else $error("answer without request");

    handoff_flag_a: assert property (run_r |-> caps.handoff_supported == (sp_value[15:12] != 4'h0))
        else $error("hand-off flag disagrees with companion count");

    route_valid_a: assert property (run_r |-> caps.route_array_valid == sp_value[`HSP_PRR_BIT])
        else $error("route array validity disagrees with routing bit");

    port_count_a: assert property (run_r |-> caps.port_count != 4'h0 && caps.port_count == sp_value[3:0])
        else $error("port count zero or inconsistent");

    power_flag_a: assert property (run_r |-> caps.port_power_switch_present == sp_value[`HSP_PPC_BIT])
        else $error("power switch flag disagrees with register");

    ports_fit_a: assert property (run_r |-> 8'(NUM_CC) * 8'(PORTS_PER_CC) >= 8'(NUM_PORTS))
        else $error("ports per companion inconsistent with port count");

    route_first_a: assert property (run_r && !ROUTE_RULE |-> port_companion[3:0] == 4'h0)
        else $error("first port not on first companion");

    // Two ports: the second one moves on only when groups hold a single port
    route_map_a: assert property (run_r && !ROUTE_RULE |-> port_companion[7:4] == 4'(PORTS_PER_CC == 4'h1))
        else $error("default grouping wrong");

    route_explicit_a: assert property (run_r && ROUTE_RULE |-> port_companion == ROUTE_ARRAY)
        else $error("explicit routing not taken from array");

    // A frozen cycle must not lose an answer the bus has not taken yet
    clock_freeze_a: assert property (!clk_en |=> $stable(resp))
        else $error("answer changed while clock enable low");

    caps_const_a: assert property (run_r |=> $stable(caps) && $stable(port_companion))
        else $error("capability outputs changed after start");

    reserved_zero_a: assert property (read_sp_s |=> resp.rdata[31:16] == 16'h0 && resp.rdata[6:5] == 2'h0)
        else $error("reserved bits read nonzero");

    companion_flag_a: assert property (run_r |-> caps.companion_present == caps.handoff_supported)
        else $error("companion and hand-off flags disagree");

endmodule

//--- tb/hsp_struct_params_tb.sv
// Self-checking bench for the structural parameters register block
`timescale 1ns/1ps
module hsp_struct_params_tb;
import hsp_pkg::*;

typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic hit;
    logic [31:0] rdata;
} hsp_row_type;

// Built field by field so a wrong position in the design shows up
localparam logic [31:0] SP_EXP = {16'h0000, 4'h1, 4'h2, 1'h1, 2'h0, 1'h1, 4'h2};

logic clk = 1'b0;
logic rstn = 1'b0;
logic clk_en = 1'b1;
hsp_req_type acc = '0;
hsp_resp_type resp;
hsp_caps_type caps;
logic [7:0] port_companion;
hsp_resp_type grp_resp;
hsp_caps_type grp_caps;
logic [7:0] grp_companion;
int failures = 0;
int tests_run = 0;
int cycles = 0;
hsp_row_type rows [8];

always #2.5 clk = ~clk;

// Port 1 sent to companion 1 so the route array is visible at the outputs
hsp_struct_params #(.ROUTE_ARRAY(8'h10)) dut_u (
    .clk(clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .acc(acc),
    .resp(resp),
    .caps(caps),
    .port_companion(port_companion)
);

// Grouped routing, two companions of one port each, no power switches; bus kept idle
hsp_struct_params #(
    .NUM_CC(4'h2),
    .PORTS_PER_CC(4'h1),
    .ROUTE_RULE(1'h0),
    .POWER_SWITCH(1'h0)
) dut_grp_u (
    .clk(clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .acc('0),
    .resp(grp_resp),
    .caps(grp_caps),
    .port_companion(grp_companion)
);

task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask

// Whole run needs about fifty cycles
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
        failures = failures + 1;
        wrap_up();
    end
end

// Wide enough for the ack bit beside a full data word
task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
endtask

// Internal reset lifts two edges after release, caps load on the third
task automatic wake;
    @(posedge clk) rstn <= 1'b1;
    repeat (3) @(posedge clk);
endtask

task automatic check_caps;
    @(negedge clk);
    chk(caps.companion_present, 32'h1, "companion present");
    chk(caps.handoff_supported, 32'h1, "handoff");
    chk(caps.route_array_valid, 32'h1, "route valid");
    chk(caps.port_power_switch_present, 32'h1, "power switch");
    chk(caps.port_count, 32'h2, "port count");
    chk(port_companion, 32'h10, "companion per port");
    chk({grp_resp.ack, grp_caps}, 32'hc2, "grouped caps");
    chk(grp_companion, 32'h10, "grouped routing");
endtask

task automatic do_acc(input hsp_row_type r);
    @(posedge clk) acc <= '{1'h1, r.we, r.addr, r.wdata};
    @(posedge clk) acc.req <= 1'h0;
    @(negedge clk);
    chk(resp.ack, 32'h1, "ack");
    chk(resp.hit, r.hit, "hit");
    chk(resp.rdata, r.rdata, "rdata");
    @(negedge clk);
    chk({resp.ack, resp.rdata}, 33'h0, "idle after access");
endtask

initial begin
    rows = '{
        '{1'h0, 8'h04, 32'h0, 1'h1, SP_EXP},
        '{1'h1, 8'h04, 32'hffff_ffff, 1'h1, 32'h0},
        '{1'h0, 8'h04, 32'h0, 1'h1, SP_EXP},
        '{1'h1, 8'h04, 32'h0, 1'h1, 32'h0},
        '{1'h0, 8'h00, 32'h0, 1'h0, 32'h0},
        '{1'h0, 8'h08, 32'h0, 1'h0, 32'h0},
        '{1'h0, 8'h0c, 32'h0, 1'h0, 32'h0},
        '{1'h1, 8'h05, 32'h1234_5678, 1'h0, 32'h0}
    };
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({resp.ack, caps}, 32'h0, "outputs in reset");
    wake();
    check_caps();
    $display("reset values done");
    foreach (rows[i]) begin
        do_acc(rows[i]);
    end
    $display("access table done");
    // Write then reads back to back, the write must not reach the image
    @(posedge clk) acc <= '{1'h1, 1'h1, 8'h04, 32'hffff_ffff};
    @(posedge clk) acc.we <= 1'h0;
    @(negedge clk);
    chk({resp.ack, resp.rdata}, {1'h1, 32'h0}, "write answer");
    @(posedge clk);
    @(posedge clk) acc.req <= 1'h0;
    @(negedge clk);
    chk(resp.rdata, SP_EXP, "second read");
    @(negedge clk);
    chk(resp.ack, 32'h0, "ack drops");
    $display("back to back done");
    // Clock enable low must hold the answer
    @(posedge clk) acc <= '{1'h1, 1'h0, 8'h04, 32'h0};
    @(posedge clk) acc.req <= 1'h0;
    clk_en <= 1'b0;
    repeat (2) @(negedge clk);
    chk({resp.ack, resp.rdata}, {1'h1, SP_EXP}, "held answer");
    @(posedge clk) clk_en <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(resp.ack, 32'h0, "released");
    $display("clock enable done");
    // Reset in mid-run clears, then values come back unchanged
    @(posedge clk) rstn <= 1'b0;
    @(negedge clk);
    chk({resp.ack, caps, port_companion}, 32'h0, "mid reset");
    wake();
    check_caps();
    do_acc(rows[0]);
    $display("mid-run reset done");
    wrap_up();
end

endmodule
